// file: port0_in_mux_pkg.sv
/*
 * Shared definitions for the port 0 input pin decoder: interface modes,
 * pin and sample carriers, timing constants and reset values.
 * Assumes a single system clock at CLK_SYS_HZ and a link clock far slower.
 */
package port0_in_mux_pkg;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int unsigned CLK_SYS_HZ       = 40_000_000;
  localparam int unsigned REF_CLOCK_OUT_HZ = 5_000_000;
  localparam int unsigned REF_HALF_CYCLES  = CLK_SYS_HZ / (2 * REF_CLOCK_OUT_HZ);
  localparam int unsigned DIV_W            = 3;
  localparam logic [DIV_W-1:0] DIV_LAST    = DIV_W'(REF_HALF_CYCLES - 1);
  localparam int unsigned SYNC_STAGES      = 2;

  // ==========================================================================
  // Field positions and reset values
  // ==========================================================================
  localparam int unsigned NIBBLE_W   = 4;
  localparam int unsigned BIT_ZERO   = 0;
  localparam int unsigned BIT_ONE    = 1;
  localparam int unsigned BIT_TWO    = 2;
  localparam int unsigned PIN_W      = NIBBLE_W + 4;
  localparam logic [NIBBLE_W-1:0] NIBBLE_RST = 4'h0;
  localparam logic [DIV_W-1:0]    DIV_RST    = 3'h0;
  localparam logic [1:0]          DLY_RST    = 2'h0;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [1:0] {
    MODE_MII_MAC,
    MODE_MII_PHY,
    MODE_RMII_PHY
  } port_mode_e;

  typedef struct packed {
    logic [NIBBLE_W-1:0] port0_in_nibble;
    logic                port0_in_valid_flag;
    logic                port0_in_error_flag;
    logic                port0_in_ref_clock;
    logic                rmii_ref_clock;
  } pin_in_s;

  typedef struct packed {
    logic [NIBBLE_W-1:0] nibble;
    logic                valid;
    logic                rx_error;
    logic                tx_abort;
    logic                strobe;
  } sample_s;

endpackage

// file: pin_sync.sv
/*
 * Two-stage synchroniser for a vector of independent level inputs.
 * Assumes each bit is a slow level or is sampled only after settling.
 */
`timescale 1ns/1ps

module pin_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             i_clk_sys,
  input  wire logic             i_rst,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  typedef struct packed {
    logic [WIDTH-1:0] first;
    logic [WIDTH-1:0] second;
  } sync_state_s;

  sync_state_s state_reg;
  sync_state_s state_next;

  // ==========================================================================
  // Stages
  // ==========================================================================
  // The first stage feeds only the second; nothing else looks at it.
  always_comb begin
    state_next.first  = i_async;
    state_next.second = state_reg.first;
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_sync = state_reg.second;

endmodule

// file: port0_in_mux.sv
/*
 * Port 0 input pin decoder: samples the inbound nibble, valid and error pins
 * in MII MAC, MII PHY or RMII PHY mode and presents one sample per rising link
 * clock edge to the switch. Drives the reference clock toward an external
 * MAC in MII PHY mode.
 * Assumes the link clocks are well below half of i_clk_sys, so that a
 * sampled edge can be found, and that i_mode changes only while idle.
 * Link clocks are found by oversampling, so real 25 MHz or 50 MHz link
 * clocks need a faster system clock than this one.
 * The isolate input acts only in the two PHY-side modes.
 */
`timescale 1ns/1ps

// Behaviour
// - In MII MAC mode all four nibble bits are taken as receive data from the PHY.
// - In MII PHY mode all four nibble bits, bit 2 included, are transmit data from the MAC.
// - In RMII PHY mode bit 2 is ignored and only the lower two bits carry data.
// - In RMII PHY mode bits 1 and 0 are the two-bit transmit data from the MAC.
// - In MII MAC mode the PHY drives valid as receive valid, which qualifies nibble and error.
// - In MII PHY mode the MAC drives valid as transmit enable, qualifying nibble and error.
// - In the PHY-side modes the isolate bit disables the data and valid input buffers.
// - In the MII modes the port clock times the inputs; the PHY drives it in MAC mode, we do in MII PHY mode.
// - In MII PHY mode an asserted error line is a request to abort the current frame.
// - In RMII PHY mode valid is transmit enable and qualifies only bits 1 and 0.
module port0_in_mux (
  input  wire logic                                i_clk_sys,
  input  wire logic                                i_rst,
  input  wire port0_in_mux_pkg::port_mode_e        i_mode,
  input  wire logic                                i_virtual_phy_isolate_bit,
  input  wire logic [port0_in_mux_pkg::NIBBLE_W-1:0] i_port0_in_nibble,
  input  wire logic                                i_port0_in_valid_flag,
  input  wire logic                                i_port0_in_error_flag,
  input  wire logic                                i_port0_in_ref_clock,
  input  wire logic                                i_rmii_ref_clock,
  output logic                                     o_port0_in_ref_clock,
  output logic                                     o_port0_in_ref_clock_oe,
  output logic                                     o_in_buffer_enable,
  output logic [port0_in_mux_pkg::NIBBLE_W-1:0]    o_nibble,
  output logic                                     o_valid,
  output logic                                     o_rx_error,
  output logic                                     o_tx_abort,
  output logic                                     o_strobe,
  output logic                                     o_frame_aborted,
  output logic                                     o_mode_fault
);

  // ==========================================================================
  // State
  // ==========================================================================
  // All state is one packed struct; state_next holds its value for the next edge.
  typedef struct packed {
    logic                                  ref_prev;
    logic                                  rmii_prev;
    logic [port0_in_mux_pkg::DIV_W-1:0]    div_cnt;
    logic                                  clk_out;
    logic                                  clk_oe;
    logic [1:0]                            clk_dly;
    logic                                  buf_en;
    port0_in_mux_pkg::sample_s             sample;
    logic                                  frame_aborted;
    logic                                  mode_fault;
  } mux_state_s;

  mux_state_s                 state_reg;
  mux_state_s                 state_next;
  port0_in_mux_pkg::pin_in_s  pins_raw;
  port0_in_mux_pkg::pin_in_s  pins_sync;

  // ==========================================================================
  // Pin synchronisers
  // ==========================================================================
  assign pins_raw.port0_in_nibble     = i_port0_in_nibble;
  assign pins_raw.port0_in_valid_flag = i_port0_in_valid_flag;
  assign pins_raw.port0_in_error_flag = i_port0_in_error_flag;
  assign pins_raw.port0_in_ref_clock  = i_port0_in_ref_clock;
  assign pins_raw.rmii_ref_clock      = i_rmii_ref_clock;

  // Data and clock share one synchroniser depth, so the setup margin the
  // far end gives around its clock edge is kept after sampling.
  pin_sync #(
    .WIDTH (port0_in_mux_pkg::PIN_W)
  ) u_pin_sync (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_async   (pins_raw),
    .o_sync    (pins_sync)
  );

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    logic phy_side;
    logic isolated;
    logic mode_ok;
    logic edge_seen;
    logic dv;
    logic er;
    logic [port0_in_mux_pkg::NIBBLE_W-1:0] nib;

    phy_side  = 1'b0;
    isolated  = 1'b0;
    mode_ok   = 1'b1;
    edge_seen = 1'b0;
    dv        = pins_sync.port0_in_valid_flag;
    er        = pins_sync.port0_in_error_flag;
    nib       = pins_sync.port0_in_nibble;

    state_next            = state_reg;
    state_next.ref_prev   = pins_sync.port0_in_ref_clock;
    state_next.rmii_prev  = pins_sync.rmii_ref_clock;
    state_next.clk_dly    = {state_reg.clk_dly[0], state_reg.clk_out};
    state_next.sample.strobe   = 1'b0;
    state_next.sample.tx_abort = 1'b0;

    // Free-running divider; it only reaches the pin in MII PHY mode.
    // Running it in every mode keeps its phase steady across isolate and
    // mode changes, at the cost of a little idle toggling.
    if (state_reg.div_cnt == port0_in_mux_pkg::DIV_LAST) begin
      state_next.div_cnt = port0_in_mux_pkg::DIV_RST;
      state_next.clk_out = ~state_reg.clk_out;
    end else begin
      state_next.div_cnt = state_reg.div_cnt + 1'b1;
    end

    case (i_mode)
      port0_in_mux_pkg::MODE_MII_MAC: begin
        // The external PHY owns the clock here.
        edge_seen = pins_sync.port0_in_ref_clock & ~state_reg.ref_prev;
      end
      port0_in_mux_pkg::MODE_MII_PHY: begin
        phy_side = 1'b1;
        // Our own clock, delayed to line up with the synchronised data.
        // The delay is one register stage, one fewer than the two pin synchroniser stages.
        edge_seen = state_reg.clk_dly[0] & ~state_reg.clk_dly[1];
      end
      port0_in_mux_pkg::MODE_RMII_PHY: begin
        phy_side = 1'b1;
        // The port clock pin is idle here; the reference clock has its own input.
        // Each dibit is presented alone; pairing into nibbles is left downstream.
        edge_seen = pins_sync.rmii_ref_clock & ~state_reg.rmii_prev;
        // Bit 2, bit 3 and the error pin carry nothing in this mode.
        nib = {2'h0, pins_sync.port0_in_nibble[port0_in_mux_pkg::BIT_ONE:
                                                port0_in_mux_pkg::BIT_ZERO]};
        er  = 1'b0;
      end
      default: begin
        // Code 3 selects no path; the buffers stay off so floating pins cost nothing.
        mode_ok = 1'b0;
      end
    endcase

    isolated = phy_side & i_virtual_phy_isolate_bit;

    state_next.mode_fault = ~mode_ok;
    state_next.buf_en     = mode_ok & ~isolated;
    state_next.clk_oe     = (i_mode == port0_in_mux_pkg::MODE_MII_PHY) & ~isolated;

    if (!mode_ok || isolated) begin
      // Disabled buffers read as nothing: the frame in progress ends here.
      // No strobe is raised, so nothing leaks out while the pins float.
      state_next.sample.valid    = 1'b0;
      state_next.sample.rx_error = 1'b0;
      state_next.sample.nibble   = port0_in_mux_pkg::NIBBLE_RST;
      state_next.frame_aborted   = 1'b0;
    end else if (edge_seen) begin
      state_next.sample.strobe = 1'b1;
      state_next.sample.valid  = dv;
      // Data and error mean nothing outside valid, so they read as zero there.
      state_next.sample.nibble =
        dv ? nib : port0_in_mux_pkg::NIBBLE_RST;
      state_next.sample.rx_error =
        dv & er & (i_mode == port0_in_mux_pkg::MODE_MII_MAC);
      if (dv && er && i_mode == port0_in_mux_pkg::MODE_MII_PHY) begin
        // Abort request from the MAC; held until transmit enable drops.
        // The level lets the switch drop the frame even if it misses the pulse.
        state_next.sample.tx_abort = 1'b1;
        state_next.frame_aborted   = 1'b1;
      end else if (!dv) begin
        state_next.frame_aborted = 1'b0;
      end
    end
  end

  // ==========================================================================
  // Registers
  // ==========================================================================
  // Reset is synchronous and names each field, so none is left undefined.
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      state_reg.ref_prev      <= 1'b0;
      state_reg.rmii_prev     <= 1'b0;
      state_reg.div_cnt       <= port0_in_mux_pkg::DIV_RST;
      state_reg.clk_out       <= 1'b0;
      state_reg.clk_oe        <= 1'b0;
      state_reg.clk_dly       <= port0_in_mux_pkg::DLY_RST;
      state_reg.buf_en        <= 1'b0;
      state_reg.sample        <= '0;
      state_reg.frame_aborted <= 1'b0;
      state_reg.mode_fault    <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  // Each output is a register bit, so the switch never sees decode glitches.
  assign o_port0_in_ref_clock    = state_reg.clk_out;
  assign o_port0_in_ref_clock_oe = state_reg.clk_oe;
  assign o_in_buffer_enable      = state_reg.buf_en;
  assign o_nibble                = state_reg.sample.nibble;
  assign o_valid                 = state_reg.sample.valid;
  assign o_rx_error              = state_reg.sample.rx_error;
  assign o_tx_abort              = state_reg.sample.tx_abort;
  assign o_strobe                = state_reg.sample.strobe;
  assign o_frame_aborted         = state_reg.frame_aborted;
  assign o_mode_fault            = state_reg.mode_fault;

endmodule

// file: port0_in_mux_properties.sv
/* Concurrent checks on the ports of the port 0 input decoder.
   Assumes it is bound into port0_in_mux and sees only its ports. */
`timescale 1ns/1ps

module port0_in_mux_properties (
  input wire logic                          i_clk_sys,
  input wire logic                          i_rst,
  input wire port0_in_mux_pkg::port_mode_e  i_mode,
  input wire logic                          i_virtual_phy_isolate_bit,
  input wire logic                          o_port0_in_ref_clock,
  input wire logic                          o_port0_in_ref_clock_oe,
  input wire logic                          o_in_buffer_enable,
  input wire logic [3:0]                    o_nibble,
  input wire logic                          o_valid,
  input wire logic                          o_rx_error,
  input wire logic                          o_tx_abort,
  input wire logic                          o_strobe,
  input wire logic                          o_frame_aborted,
  input wire logic                          o_mode_fault
);
  // ====================
  // Helpers
  // ====================
  wire logic is_phy  = (i_mode == port0_in_mux_pkg::MODE_MII_PHY);
  wire logic is_mac  = (i_mode == port0_in_mux_pkg::MODE_MII_MAC);
  wire logic is_rmii = (i_mode == port0_in_mux_pkg::MODE_RMII_PHY);
  wire logic iso     = i_virtual_phy_isolate_bit;
  wire logic phy_ok  = is_phy && !iso;

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  // ====================
  // Assertions
  // ====================
  a_strobe_one_shot: assert property (o_strobe |=> !o_strobe)
    else $error("strobe lasted more than one cycle");
  a_abort_phy_only: assert property (
    o_tx_abort |-> o_strobe && o_valid && is_phy)
    else $error("abort outside a valid sample in phy mode");
  a_abort_marks_frame: assert property (o_tx_abort |-> o_frame_aborted)
    else $error("abort without frame aborted flag");
  a_rmii_high_zero: assert property (
    o_strobe && is_rmii |-> o_nibble[3:2] == 2'h0)
    else $error("upper bits carried data in rmii mode");
  a_idle_data_zero: assert property (
    o_strobe && !o_valid |-> o_nibble == 4'h0 && !o_rx_error)
    else $error("data passed without valid");
  a_iso_quiet: assert property (
    (iso && !is_mac)[*3] |-> !o_strobe && !o_valid)
    else $error("sample taken while isolated");
  a_iso_buffers: assert property (iso && !is_mac |=> !o_in_buffer_enable)
    else $error("input buffers enabled while isolated");
  a_clock_drive: assert property (phy_ok |=> o_port0_in_ref_clock_oe)
    else $error("clock pin not driven in phy mode");
  a_clock_release: assert property (!phy_ok |=> !o_port0_in_ref_clock_oe)
    else $error("clock pin driven outside phy mode");
  a_clk_div: assert property (
    $rose(o_port0_in_ref_clock) |-> o_port0_in_ref_clock[*4] ##1 !o_port0_in_ref_clock)
    else $error("output clock high time wrong");
  a_phy_sample: assert property (
    ($rose(o_port0_in_ref_clock) ##0 phy_ok[*3]) |-> o_strobe)
    else $error("no sample two cycles after own clock edge was seen");
  a_mode_fault: assert property (
    2'(i_mode) == 2'h3 |=> o_mode_fault && !o_in_buffer_enable)
    else $error("unknown mode not flagged");

  c_abort: cover property (o_tx_abort);
  c_rmii: cover property (o_strobe && o_valid && is_rmii);
  c_mac_err: cover property (o_strobe && o_rx_error && is_mac);
endmodule

bind port0_in_mux port0_in_mux_properties u_port0_in_mux_properties (
  .i_clk_sys                 (i_clk_sys),
  .i_rst                     (i_rst),
  .i_mode                    (i_mode),
  .i_virtual_phy_isolate_bit (i_virtual_phy_isolate_bit),
  .o_port0_in_ref_clock      (o_port0_in_ref_clock),
  .o_port0_in_ref_clock_oe   (o_port0_in_ref_clock_oe),
  .o_in_buffer_enable        (o_in_buffer_enable),
  .o_nibble                  (o_nibble),
  .o_valid                   (o_valid),
  .o_rx_error                (o_rx_error),
  .o_tx_abort                (o_tx_abort),
  .o_strobe                  (o_strobe),
  .o_frame_aborted           (o_frame_aborted),
  .o_mode_fault              (o_mode_fault)
);

// file: port0_in_partner.sv
/* Behavioural model of the external PHY or MAC on port 0.
   Assumes send() is called only while the mode stays unchanged. */
`timescale 1ns/1ps

module port0_in_partner (
  input  wire port0_in_mux_pkg::port_mode_e i_mode,
  input  wire logic                         i_dut_clock,
  output logic [3:0]                        o_nibble,
  output logic                              o_valid,
  output logic                              o_error,
  output logic                              o_ref_clock,
  output logic                              o_rmii_clock
);
  // ====================
  // Transfers
  // ====================
  initial {o_nibble, o_valid, o_error, o_ref_clock, o_rmii_clock} = 8'h00;

  // Link clocks stand still between transfers; released pins fall to their pull-downs.
  // In MAC and RMII modes a nonzero gap delays the link edge to act as a slow partner.
  task automatic send(input logic [3:0] nib, input logic v, input logic e, input int gap);
    // In MII PHY mode pins move just after the falling edge of the block's clock, off the sampling edge of the block.
    if (i_mode == port0_in_mux_pkg::MODE_MII_PHY) begin
      @(negedge i_dut_clock);
      #1;
    end
    {o_nibble, o_valid, o_error} = {nib, v, e};
    if (i_mode == port0_in_mux_pkg::MODE_MII_PHY) begin
      @(negedge i_dut_clock);
      #1;
    end else begin
      #(100 + gap);
      if (i_mode == port0_in_mux_pkg::MODE_RMII_PHY) o_rmii_clock = 1'b1;
      else o_ref_clock = 1'b1;
      #100;
      {o_ref_clock, o_rmii_clock} = 2'h0;
    end
    {o_nibble, o_valid, o_error} = 6'h00;
  endtask
endmodule

// file: port0_in_mux_bench.sv
/* Self-checking bench for the port 0 input decoder and its partner model.
   Assumes the package, design and checker files are compiled first. */
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin bad_count++; \
  $display("MISMATCH %s exp=%0h got=%0h", n, e, g); end end

module port0_in_mux_bench;
  logic                         i_clk_sys, i_rst, i_virtual_phy_isolate_bit;
  port0_in_mux_pkg::port_mode_e i_mode;
  logic [3:0]                   i_port0_in_nibble, o_nibble, s_nib;
  logic                         i_port0_in_valid_flag, i_port0_in_error_flag;
  logic                         i_port0_in_ref_clock, i_rmii_ref_clock;
  logic                         o_port0_in_ref_clock, o_port0_in_ref_clock_oe;
  logic                         o_in_buffer_enable, o_valid, o_rx_error, o_tx_abort;
  logic                         o_strobe, o_frame_aborted, o_mode_fault;
  logic                         s_v, s_er, s_ab, s_fa;
  int                           bad_count, n_checks, n_strobes;

  port0_in_mux u_port0_in_mux (
    .i_clk_sys                 (i_clk_sys),
    .i_rst                     (i_rst),
    .i_mode                    (i_mode),
    .i_virtual_phy_isolate_bit (i_virtual_phy_isolate_bit),
    .i_port0_in_nibble         (i_port0_in_nibble),
    .i_port0_in_valid_flag     (i_port0_in_valid_flag),
    .i_port0_in_error_flag     (i_port0_in_error_flag),
    .i_port0_in_ref_clock      (i_port0_in_ref_clock),
    .i_rmii_ref_clock          (i_rmii_ref_clock),
    .o_port0_in_ref_clock      (o_port0_in_ref_clock),
    .o_port0_in_ref_clock_oe   (o_port0_in_ref_clock_oe),
    .o_in_buffer_enable        (o_in_buffer_enable),
    .o_nibble                  (o_nibble),
    .o_valid                   (o_valid),
    .o_rx_error                (o_rx_error),
    .o_tx_abort                (o_tx_abort),
    .o_strobe                  (o_strobe),
    .o_frame_aborted           (o_frame_aborted),
    .o_mode_fault              (o_mode_fault)
  );
  port0_in_partner u_port0_in_partner (.i_mode(i_mode), .i_dut_clock(o_port0_in_ref_clock),
    .o_nibble(i_port0_in_nibble), .o_valid(i_port0_in_valid_flag),
    .o_error(i_port0_in_error_flag), .o_ref_clock(i_port0_in_ref_clock),
    .o_rmii_clock(i_rmii_ref_clock));

  initial begin
    i_clk_sys = 1'b0;
    forever #12.5 i_clk_sys = ~i_clk_sys;
  end

  always @(posedge i_clk_sys) if (o_strobe === 1'b1) begin
    n_strobes++;
    {s_nib, s_v, s_er, s_ab, s_fa} = {o_nibble, o_valid, o_rx_error, o_tx_abort, o_frame_aborted};
  end

  // ====================
  // Helpers
  // ====================
  task automatic go(input port0_in_mux_pkg::port_mode_e m, input logic iso);
    @(posedge i_clk_sys);
    #1;
    i_mode = m;
    i_virtual_phy_isolate_bit = iso;
    repeat (3) @(posedge i_clk_sys);
    #1;
  endtask

  task automatic xfer(input logic [3:0] nib, input logic v, e, input int gap,
                      input logic [3:0] xn, input logic xv, xe, xa);
    int n0;
    n0 = n_strobes;
    u_port0_in_partner.send(nib, v, e, gap);
    #2;
    for (int i = 0; i < 20 && n_strobes == n0; i++) #25;
    `CHK("strobe", 1'b1, n_strobes > n0)
    `CHK("nibble", xn, s_nib)
    `CHK("valid", xv, s_v)
    `CHK("rx error", xe, s_er)
    `CHK("tx abort", xa, s_ab)
  endtask

  // ====================
  // Scenarios
  // ====================
  task automatic t_mac();
    go(port0_in_mux_pkg::MODE_MII_MAC, 1'b1);
    `CHK("mac buffers", 1'b1, o_in_buffer_enable)
    `CHK("mac clock oe", 1'b0, o_port0_in_ref_clock_oe)
    xfer(4'h5, 1'b1, 1'b0, 0, 4'h5, 1'b1, 1'b0, 1'b0);
    xfer(4'hC, 1'b1, 1'b1, 150, 4'hC, 1'b1, 1'b1, 1'b0);
    xfer(4'hA, 1'b0, 1'b1, 0, 4'h0, 1'b0, 1'b0, 1'b0);
    $display("t_mac done");
  endtask

  task automatic t_phy();
    go(port0_in_mux_pkg::MODE_MII_PHY, 1'b0);
    `CHK("phy clock oe", 1'b1, o_port0_in_ref_clock_oe)
    xfer(4'h4, 1'b1, 1'b0, 0, 4'h4, 1'b1, 1'b0, 1'b0);
    xfer(4'h9, 1'b1, 1'b1, 0, 4'h9, 1'b1, 1'b0, 1'b1);
    `CHK("aborted set", 1'b1, s_fa)
    xfer(4'hF, 1'b0, 1'b1, 0, 4'h0, 1'b0, 1'b0, 1'b0);
    #50;
    `CHK("aborted clear", 1'b0, o_frame_aborted)
    $display("t_phy done");
  endtask

  task automatic t_rmii();
    go(port0_in_mux_pkg::MODE_RMII_PHY, 1'b0);
    xfer(4'hF, 1'b1, 1'b1, 0, 4'h3, 1'b1, 1'b0, 1'b0);
    xfer(4'h6, 1'b1, 1'b0, 90, 4'h2, 1'b1, 1'b0, 1'b0);
    xfer(4'h3, 1'b0, 1'b0, 0, 4'h0, 1'b0, 1'b0, 1'b0);
    $display("t_rmii done");
  endtask

  task automatic t_iso();
    int n0;
    for (int m = 1; m < 3; m++) begin
      go(port0_in_mux_pkg::port_mode_e'(m), 1'b1);
      n0 = n_strobes;
      u_port0_in_partner.send(4'hF, 1'b1, 1'b0, 0);
      repeat (12) @(posedge i_clk_sys);
      #1;
      `CHK("iso strobes", n0, n_strobes)
      `CHK("iso buffers", 1'b0, o_in_buffer_enable)
      `CHK("iso clock oe", 1'b0, o_port0_in_ref_clock_oe)
      `CHK("iso valid", 1'b0, o_valid)
    end
    $display("t_iso done");
  endtask

  task automatic t_fault();
    go(port0_in_mux_pkg::port_mode_e'(2'h3), 1'b0);
    `CHK("fault set", 1'b1, o_mode_fault)
    `CHK("fault buffers", 1'b0, o_in_buffer_enable)
    go(port0_in_mux_pkg::MODE_MII_MAC, 1'b0);
    `CHK("fault clear", 1'b0, o_mode_fault)
    $display("t_fault done");
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // The whole sequence needs well under 2000 cycles; this leaves a wide margin.
  initial begin
    #100_000;
    bad_count++;
    close_out();
  end

  initial begin
    {i_rst, i_virtual_phy_isolate_bit, i_mode} = {1'b1, 1'b0, port0_in_mux_pkg::MODE_MII_MAC};
    repeat (5) @(posedge i_clk_sys);
    #1;
    i_rst = 1'b0;
    t_mac();
    t_phy();
    t_rmii();
    t_iso();
    t_fault();
    close_out();
  end
endmodule
